// ===== core/mau_consts.svh
// Constants of the multiply-accumulate unit: field positions, rounding constants, reset values.
// Assumes nothing beyond being included by its bare name.
`ifndef MAU_CONSTS_SVH
`define MAU_CONSTS_SVH

// Operand halfword positions (integer mode uses the low-order one)
`define MAU_HALF_INT_MSB 15
`define MAU_HALF_INT_LSB 0
`define MAU_HALF_FRAC_MSB 31
`define MAU_HALF_FRAC_LSB 16

// Destination register takes the low word of the 64-bit result
`define MAU_GR_MSB 31
`define MAU_GR_LSB 0

// Rounding constants and the word-rounding keep mask
`define MAU_ROUND_HALF 64'h0000_0000_0000_8000
`define MAU_ROUND_WORD 64'h0000_0000_8000_0000
`define MAU_WORD_KEEP 64'hFFFF_FFFF_0000_0000

// Reset values
`define MAU_ACC_RST 64'h0000_0000_0000_0000
`define MAU_GR_RST 32'h0000_0000
`define MAU_DEST_RST 5'h00

`endif

// ===== core/mau_pkg.sv
// Types of the multiply-accumulate unit.
// Assumes the constants header is compiled alongside.
package mau_pkg;

   // Operation select, as presented by the pipeline
   typedef enum logic [1:0] {
      MAU_HALF_MUL_SUB_UNSIGNED,
      MAU_WORD_MUL_ACC_SIGNED,
      MAU_WORD_MUL_ACC_UNSIGNED,
      MAU_WORD_MUL_SUB_SIGNED
   } mau_op_e;

   // Top-level sequencing
   typedef enum logic [0:0] {
      MAU_IDLE,
      MAU_MUL
   } mau_state_e;

   // Multiplier stage register
   typedef struct packed {
      logic valid;
      logic [63:0] prod;
      logic half;
      logic sub;
      logic frac;
      logic rnd;
   } mau_mul_s;

   // Top-level state
   typedef struct packed {
      mau_state_e state;
      logic ready;
      logic busy;
      logic [63:0] acc;
      logic [31:0] gr_data;
      logic gr_wr;
      logic [4:0] dest;
      logic done;
   } mau_top_s;

endpackage

// ===== core/mau_prod_if.sv
// Product path between multiplier stage, shaper and accumulator.
// Assumes all parties share one clock; no timing of its own.
`timescale 1ns/1ps
`default_nettype none
interface mau_prod_if;
   logic valid;
   logic [63:0] prod;
   logic half;
   logic sub;
   logic frac;
   logic rnd;
   logic [63:0] shaped;

   modport mult (output valid, output prod, output half, output sub, output frac, output rnd);
   modport shape (input prod, input half, input frac, input rnd, output shaped);
   modport acc (input valid, input half, input sub, input shaped);
endinterface
`default_nettype wire

// ===== core/mau_mult.sv
// First stage: operand selection, extension and the 64-bit multiply.
// Assumes start is a one-cycle accept pulse from the top; ce freezes it.
`timescale 1ns/1ps
`default_nettype none
`include "mau_consts.svh"
module mau_mult (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic start,
   input wire mau_pkg::mau_op_e op,
   input wire logic [31:0] src_a,
   input wire logic [31:0] src_b,
   input wire logic frac_mode,
   input wire logic round_en,
   mau_prod_if.mult prod_o
);
   mau_pkg::mau_mul_s q_q;
   mau_pkg::mau_mul_s q_d;

   // Extend a word to 33 bits, signed or unsigned
   function automatic logic signed [32:0] ext33(input logic [31:0] v, input logic sgn);
      ext33 = {sgn & v[31], v};
   endfunction

   // Pick the halfword by mode, zero-extended to a word
   function automatic logic [31:0] pick_half(input logic [31:0] v, input logic frac);
      pick_half = frac ? {16'h0000, v[`MAU_HALF_FRAC_MSB:`MAU_HALF_FRAC_LSB]}
                       : {16'h0000, v[`MAU_HALF_INT_MSB:`MAU_HALF_INT_LSB]};
   endfunction

   // Operand decode and multiply; one 33x33 signed array serves all cases
   always_comb begin
      logic half;
      logic sgn;
      logic signed [32:0] xa;
      logic signed [32:0] xb;
      logic signed [65:0] full;
      half = (op == mau_pkg::MAU_HALF_MUL_SUB_UNSIGNED);
      sgn = (op == mau_pkg::MAU_WORD_MUL_ACC_SIGNED) || (op == mau_pkg::MAU_WORD_MUL_SUB_SIGNED);
      // Halfwords zero-extend; words extend as the op says
      xa = half ? ext33(pick_half(src_a, frac_mode), 1'b0) : ext33(src_a, sgn); // [RQ1] [RQ2]
      xb = half ? ext33(pick_half(src_b, frac_mode), 1'b0) : ext33(src_b, sgn); // [RQ6] [RQ7] [RQ8]
      full = xa * xb;
      q_d = q_q;
      q_d.valid = start;
      if (start) begin
         q_d.prod = full[63:0];
         q_d.half = half;
         q_d.sub = half || (op == mau_pkg::MAU_WORD_MUL_SUB_SIGNED);
         q_d.frac = frac_mode; // [RQ10]
         q_d.rnd = round_en;
      end
   end

   // Stage register, held while ce is low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_q <= '0;
      end else if (ce) begin
         q_q <= q_d;
      end
   end

   assign prod_o.valid = q_q.valid;
   assign prod_o.prod = q_q.prod;
   assign prod_o.half = q_q.half;
   assign prod_o.sub = q_q.sub;
   assign prod_o.frac = q_q.frac;
   assign prod_o.rnd = q_q.rnd;
endmodule
`default_nettype wire

// ===== core/mau_shape.sv
// Product shaping: fraction doubling and rounding ahead of accumulation.
// Assumes a registered product on its input; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "mau_consts.svh"
module mau_shape (
   mau_prod_if.shape prod_io
);
   // Doubling first, then rounding, so the constant lands at the true boundary
   always_comb begin
      logic [63:0] dbl;
      logic [63:0] rsum;
      dbl = prod_io.frac ? {prod_io.prod[62:0], 1'b0} : prod_io.prod; // [RQ3] [RQ10]
      rsum = dbl;
      if (prod_io.rnd && prod_io.half) begin
         rsum = dbl + `MAU_ROUND_HALF; // [RQ4]
      end else if (prod_io.rnd) begin
         // Add half an LSB of the upper word, then drop the lower word
         rsum = (dbl + `MAU_ROUND_WORD) & `MAU_WORD_KEEP; // [RQ9]
      end
      prod_io.shaped = rsum;
   end
endmodule
`default_nettype wire

// ===== core/mau_top.sv
// Multiply-accumulate unit top: accept, two-cycle multiply/accumulate, results.
// Assumes the pipeline honours ready and holds dependent reads while busy.
//
// Operation
// RQ1: Unsigned halfword product subtracted from accumulator.
// RQ2: Integer uses low halfword, fraction high halfword.
// RQ3: Fraction halfword product doubled before combining.
// RQ4: Halfword rounding adds constant at 16-bit boundary.
// RQ5: Halfword subtract writes accumulator and low word.
// RQ6: Signed word product added to accumulator.
// RQ7: Unsigned word product added to accumulator.
// RQ8: Signed word product subtracted from accumulator.
// RQ9: Word rounding rounds at 32-bit boundary.
// RQ10: Mode bit selects integer or doubled fraction.
// RQ11: Accumulate wraps modulo 2^64, no flags.
// RQ12: Dependent reads stall until operation completes.
`timescale 1ns/1ps
`default_nettype none
`include "mau_consts.svh"
module mau_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic req_valid,
   input wire logic [1:0] req_op,
   input wire logic [31:0] req_src_a,
   input wire logic [31:0] req_src_b,
   input wire logic req_round,
   input wire logic [4:0] req_dest,
   input wire logic arith_mode_register,
   input wire logic acc_load,
   input wire logic [63:0] acc_load_data,
   output logic req_ready,
   output logic busy,
   output logic [4:0] pend_dest,
   output logic [31:0] accum_upper,
   output logic [31:0] accum_lower,
   output logic [31:0] general_register,
   output logic gr_wr,
   output logic [4:0] gr_dest,
   output logic done
);
   mau_pkg::mau_top_s s_q;
   mau_pkg::mau_top_s s_d;
   logic start;
   mau_pkg::mau_op_e op;

   mau_prod_if prod_bus();

   // An accept needs ready and a running clock enable
   assign start = req_valid && s_q.ready && ce;
   assign op = mau_pkg::mau_op_e'(req_op);

   mau_mult u_mult (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .start(start),
      .op(op),
      .src_a(req_src_a),
      .src_b(req_src_b),
      .frac_mode(arith_mode_register),
      .round_en(req_round),
      .prod_o(prod_bus.mult)
   );

   mau_shape u_shape (
      .prod_io(prod_bus.shape)
   );

   // Sequencing and accumulation; the new value is formed one cycle after accept
   always_comb begin
      logic [63:0] sum;
      sum = '0;
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.gr_wr = 1'b0;
      // Plain 64-bit add or subtract: carries out of bit 63 are dropped on purpose
      if (prod_bus.sub) begin
         sum = s_q.acc - prod_bus.shaped; // [RQ1] [RQ8] [RQ11]
      end else begin
         sum = s_q.acc + prod_bus.shaped; // [RQ6] [RQ7] [RQ11]
      end
      case (s_q.state)
         mau_pkg::MAU_IDLE: begin
            if (req_valid && s_q.ready) begin
               // Ready drops so the pipeline holds reads of the busy targets
               s_d.state = mau_pkg::MAU_MUL; // [RQ12]
               s_d.ready = 1'b0;
               s_d.busy = 1'b1;
               s_d.dest = req_dest;
            end else if (acc_load && s_q.ready) begin
               // Direct accumulator load from the pipeline, only while idle
               s_d.acc = acc_load_data;
            end
         end
         mau_pkg::MAU_MUL: begin
            if (prod_bus.valid) begin
               s_d.acc = sum;
               s_d.state = mau_pkg::MAU_IDLE;
               s_d.ready = 1'b1; // [RQ12]
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               if (prod_bus.half) begin
                  // Only the halfword subtract updates the destination register
                  s_d.gr_data = sum[`MAU_GR_MSB:`MAU_GR_LSB]; // [RQ5]
                  s_d.gr_wr = 1'b1;
               end
            end
         end
         default: begin
            s_d.state = mau_pkg::MAU_IDLE;
            s_d.ready = 1'b1;
            s_d.busy = 1'b0;
         end
      endcase
   end

   // State register; ce low freezes everything including the stage pulses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q.state <= mau_pkg::MAU_IDLE;
         s_q.ready <= 1'b1;
         s_q.busy <= 1'b0;
         s_q.acc <= `MAU_ACC_RST;
         s_q.gr_data <= `MAU_GR_RST;
         s_q.gr_wr <= 1'b0;
         s_q.dest <= `MAU_DEST_RST;
         s_q.done <= 1'b0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // Every output is a flip-flop of the state struct
   assign req_ready = s_q.ready;
   assign busy = s_q.busy; // [RQ12]
   assign pend_dest = s_q.dest;
   assign accum_upper = s_q.acc[63:32];
   assign accum_lower = s_q.acc[31:0];
   assign general_register = s_q.gr_data;
   assign gr_wr = s_q.gr_wr;
   assign gr_dest = s_q.dest;
   assign done = s_q.done;
endmodule
`default_nettype wire

// ===== dv/mau_properties.sv
// Port checker of the multiply-accumulate unit top.
// Assumes ce drops only while idle; bound to every mau_top instance.
`timescale 1ns/1ps
`default_nettype none
module mau_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic req_valid,
   input wire logic [1:0] req_op,
   input wire logic [4:0] req_dest,
   input wire logic acc_load,
   input wire logic req_ready,
   input wire logic busy,
   input wire logic [4:0] pend_dest,
   input wire logic [31:0] accum_upper,
   input wire logic [31:0] accum_lower,
   input wire logic [31:0] general_register,
   input wire logic gr_wr,
   input wire logic [4:0] gr_dest,
   input wire logic done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Accept strobe, as the pipeline sees it
   wire take = req_valid && req_ready && ce;
   property p_take; take |=> busy && !req_ready ##1 done; endproperty
   a_take: assert property (p_take) else $error("no two-cycle completion");
   property p_busy; busy == !req_ready; endproperty
   a_busy: assert property (p_busy) else $error("busy not inverse of ready");
   property p_back; !req_ready && ce |=> req_ready; endproperty
   a_back: assert property (p_back) else $error("ready stuck low");
   property p_dest; take |=> pend_dest == $past(req_dest) && gr_dest == $past(req_dest); endproperty
   a_dest: assert property (p_dest) else $error("destination not held");
   property p_grw; take && req_op == 2'h0 |=> ##1 gr_wr && done; endproperty
   a_grw: assert property (p_grw) else $error("no register write-back");
   property p_pulse; done && ce |=> !done && !gr_wr; endproperty
   a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
   property p_acc; $changed({accum_upper, accum_lower}) |-> done || $past(acc_load); endproperty
   a_acc: assert property (p_acc) else $error("accumulator changed without cause");
   property p_gr; $changed(general_register) |-> gr_wr; endproperty
   a_gr: assert property (p_gr) else $error("register changed without write");
   c_half: cover property (take && req_op == 2'h0);
   c_sub: cover property (take && req_op == 2'h3);
   c_load: cover property (acc_load && req_ready && !req_valid);
endmodule
bind mau_top mau_properties mau_properties_i (.clk, .sys_rst, .ce, .req_valid, .req_op,
   .req_dest, .acc_load, .req_ready, .busy, .pend_dest, .accum_upper, .accum_lower,
   .general_register, .gr_wr, .gr_dest, .done);
`default_nettype wire

// ===== dv/mau_pipe_model.sv
// General register file standing behind the unit's write-back port.
// Assumes write pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module mau_pipe_model (
   input wire logic clk,
   input wire logic gr_wr,
   input wire logic [4:0] gr_dest,
   input wire logic [31:0] general_register
);
   logic [31:0] gr_file [32];
   // Store each write-back; unknown strobes never write
   always @(posedge clk) begin
      if (gr_wr === 1'b1) gr_file[gr_dest] <= general_register;
   end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench of the multiply-accumulate unit.
// Assumes ce is dropped only while idle; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, sys_rst, ce, req_valid, req_round, arith_mode_register, acc_load;
   logic req_ready, busy, gr_wr, done;
   logic [1:0] req_op;
   logic [4:0] req_dest, pend_dest, gr_dest;
   logic [31:0] req_src_a, req_src_b, accum_upper, accum_lower, general_register;
   logic [63:0] acc_load_data, exp_acc;
   int err_count = 0;
   int compares = 0;
   mau_top mau_top_i (.clk, .sys_rst, .ce, .req_valid, .req_op, .req_src_a, .req_src_b,
      .req_round, .req_dest, .arith_mode_register, .acc_load, .acc_load_data, .req_ready,
      .busy, .pend_dest, .accum_upper, .accum_lower, .general_register, .gr_wr, .gr_dest,
      .done);
   mau_pipe_model mau_pipe_model_i (.clk, .gr_wr, .gr_dest, .general_register);
   // 200 MHz core clock
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Set up one request's operands and advance the reference accumulator; the caller drives req_valid
   task automatic setup(logic [1:0] op, logic [31:0] a, b, logic frac, rnd);
      logic [63:0] p;
      case (op)
         2'h0: p = frac ? 64'(a[31:16]) * 64'(b[31:16]) : 64'(a[15:0]) * 64'(b[15:0]);
         2'h2: p = 64'(a) * 64'(b);
         default: p = 64'($signed(a)) * 64'($signed(b));
      endcase
      if (frac) p = p << 1;
      if (rnd) p = op == 2'h0 ? p + 64'h8000 : (p + 64'h8000_0000) & 64'hFFFF_FFFF_0000_0000;
      exp_acc = (op == 2'h0 || op == 2'h3) ? exp_acc - p : exp_acc + p;
      {req_op, req_src_a, req_src_b, req_round, arith_mode_register} = {op, a, b, rnd, frac};
   endtask
   // Completion within a bounded wait, then results
   task automatic finish_op();
      for (int n = 0; n < 4 && done !== 1'b1; n++) @(negedge clk);
      chk("done", 1, done);
      if (done !== 1'b1) conclude();
      chk("acc", exp_acc, {accum_upper, accum_lower});
      chk("gr_wr", 64'(req_op == 2'h0), gr_wr);
      @(negedge clk);
      if (req_op == 2'h0) chk("gr", exp_acc[31:0], mau_pipe_model_i.gr_file[req_dest]);
   endtask
   task automatic run(logic [1:0] op, logic [31:0] a, b, logic frac, rnd);
      setup(op, a, b, frac, rnd);
      req_valid = 1;
      @(negedge clk);
      req_valid = 0;
      chk("busy", 1, busy);
      finish_op();
   endtask
   task automatic load(logic [63:0] v);
      {acc_load, acc_load_data, exp_acc} = {1'b1, v, v};
      @(negedge clk);
      acc_load = 0;
   endtask
   task automatic t_half();
      load(64'h0000_0001_0000_0000);
      for (int i = 0; i < 4; i++) begin
         req_dest = 5'(i + 1);
         run(2'h0, 32'h8001_FFFF, 32'hC003_FFFF, i[1], i[0]);
      end
      $display("t_half done");
   endtask
   task automatic t_word();
      for (int op = 1; op < 4; op++) begin
         for (int f = 0; f < 2; f++) run(2'(op), 32'hFFFF_8001, 32'h7FFF_C003, f[0], op[0] ^ f[0]);
      end
      $display("t_word done");
   endtask
   task automatic t_wrap();
      load(64'hFFFF_FFFF_FFFF_FFF0);
      run(2'h2, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b1, 1'b0);
      load(64'h0);
      run(2'h0, 32'h0000_0003, 32'h0000_0005, 1'b0, 1'b1);
      $display("t_wrap done");
   endtask
   // Clock enable low while idle: a request and a load are both held off
   task automatic t_freeze();
      {ce, req_valid, acc_load, acc_load_data} = {3'b011, 64'h1234};
      repeat (3) @(negedge clk);
      {req_valid, acc_load} = 2'b00;
      chk("frozen acc", exp_acc, {accum_upper, accum_lower});
      chk("frozen ready", 1, req_ready);
      chk("frozen busy", 0, busy);
      ce = 1;
      $display("t_freeze done");
   endtask
   // A load beside a request loses, and both held into the busy cycle are refused
   task automatic t_refuse();
      setup(2'h3, 32'h8000_0000, 32'h8000_0001, 1'b0, 1'b1);
      {req_valid, acc_load, acc_load_data} = {2'b11, 64'h0};
      repeat (2) @(negedge clk);
      {req_valid, acc_load} = 2'b00;
      finish_op();
      $display("t_refuse done");
   endtask
   // Reset, then each scenario in turn
   initial begin
      {sys_rst, ce, req_valid, acc_load, acc_load_data, exp_acc} = {2'b11, 130'h0};
      {req_op, req_src_a, req_src_b, req_round, arith_mode_register, req_dest} = '0;
      repeat (10) @(negedge clk);
      sys_rst = 0;
      t_half();
      t_word();
      t_wrap();
      t_freeze();
      t_refuse();
      conclude();
   end
endmodule
`default_nettype wire
